// ### hw/ser_dec_conv.sv
// Sequential binary to decimal digit converter
`timescale 1ns/1ps
module ser_dec_conv (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      start_i,
    input  wire logic [ser_pkg::REG_W-1:0] bin_i,
    output logic                           done_o,
    output logic [ser_pkg::BCD_W-1:0]      bcd_o
);
    import ser_pkg::*;

    ser_conv_st_t st;
    ser_conv_st_t next_st;

    // Shift-and-add-three on every digit
    function automatic logic [BCD_W-1:0] adjust(input logic [BCD_W-1:0] v);
        logic [BCD_W-1:0] r;
        r = v;
        for (int i = 0; i < DIGITS; i++) begin
            if (r[4*i +: 4] >= 4'h5) begin
                r[4*i +: 4] = r[4*i +: 4] + 4'h3;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [BCD_W-1:0] adj;
        adj     = adjust(st.bcd);
        next_st = st;
        case (st.state)
            CV_IDLE: begin
                if (start_i) begin
                    next_st.state = CV_RUN;
                    next_st.steps = STEP_W'(CONV_STEPS);
                    next_st.shreg = bin_i;
                    next_st.bcd   = '0;
                end
            end
            CV_RUN: begin
                next_st.bcd   = {adj[BCD_W-2:0], st.shreg[REG_W-1]};
                next_st.shreg = {st.shreg[REG_W-2:0], 1'b0};
                next_st.steps = st.steps - 5'h01;
                if (st.steps == 5'h01) begin
                    next_st.state = CV_DONE;
                end
            end
            CV_DONE: begin
                next_st.state = CV_IDLE;
            end
            default: begin
                next_st.state = CV_IDLE;
            end
        endcase
        if (!nrst_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign done_o = (st.state == CV_DONE);
    assign bcd_o  = st.bcd;

endmodule // ser_dec_conv

// ### hw/ser_pkg.sv
// Shared types and constants for the status event register bank
package ser_pkg;

    // ==========================================================
    // Widths and counts
    localparam int REG_W      = 16;
    localparam int CNT_W      = 16;
    localparam int DIGITS     = 5;
    localparam int BCD_W      = 4 * DIGITS;
    localparam int CONV_STEPS = 16;
    localparam int STEP_W     = 5;

    // ==========================================================
    // Measurement event bit positions
    localparam int M_OVERRANGE   = 0;
    localparam int M_BELOW_ONE   = 1;
    localparam int M_ABOVE_ONE   = 2;
    localparam int M_BELOW_TWO   = 3;
    localparam int M_ABOVE_TWO   = 4;
    localparam int M_READY       = 5;
    localparam int M_BUF_TWO     = 7;
    localparam int M_BUF_HALF    = 8;
    localparam int M_BUF_NOSPACE = 9;

    // Questionable event bit positions
    localparam int Q_JUNCTION    = 4;
    localparam int Q_CAL_CONST   = 8;
    localparam int Q_SELF_ADJUST = 9;

    // Operation event bit positions
    localparam int O_CALIBRATING = 0;
    localparam int O_MEASURING   = 4;
    localparam int O_TRIG_WAIT   = 5;
    localparam int O_FILTER_OK   = 8;
    localparam int O_IDLE        = 10;

    // Implemented bits; all others read as zero
    localparam logic [15:0] MEAS_MASK = 16'h03BF;
    localparam logic [15:0] QUES_MASK = 16'h0310;
    localparam logic [15:0] OPER_MASK = 16'h0531;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ==========================================================
    // Query and enable selectors
    localparam logic [2:0] QRY_MEAS_EV   = 3'h0;
    localparam logic [2:0] QRY_QUES_EV   = 3'h1;
    localparam logic [2:0] QRY_OPER_EV   = 3'h2;
    localparam logic [2:0] QRY_MEAS_COND = 3'h3;
    localparam logic [2:0] QRY_QUES_COND = 3'h4;
    localparam logic [2:0] QRY_OPER_COND = 3'h5;
    localparam logic [1:0] EN_MEAS       = 2'h0;
    localparam logic [1:0] EN_QUES       = 2'h1;
    localparam logic [1:0] EN_OPER       = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic reading_overrange;
        logic below_lower_bound_one;
        logic above_upper_bound_one;
        logic below_lower_bound_two;
        logic above_upper_bound_two;
        logic new_reading_ready;
    } ser_meas_src_t;

    typedef struct packed {
        logic junction_invalid;
        logic cal_const_bad;
        logic cal_ok;
        logic self_adjust_invalid;
        logic self_adjust_ok;
    } ser_ques_src_t;

    typedef struct packed {
        logic calibrating;
        logic measuring;
        logic trig_wait;
        logic filter_settled;
        logic idle;
    } ser_oper_src_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] sel;
    } ser_query_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  sel;
        logic [15:0] data;
    } ser_enable_wr_t;

    typedef struct packed {
        logic             valid;
        logic [BCD_W-1:0] digits;
    } ser_reply_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01,
        CV_DONE = 2'b10
    } ser_conv_state_t;

    typedef struct packed {
        ser_conv_state_t   state;
        logic [STEP_W-1:0] steps;
        logic [REG_W-1:0]  shreg;
        logic [BCD_W-1:0]  bcd;
    } ser_conv_st_t;

    typedef struct packed {
        logic [REG_W-1:0] meas_ev;
        logic [REG_W-1:0] ques_ev;
        logic [REG_W-1:0] oper_ev;
        logic [REG_W-1:0] meas_en;
        logic [REG_W-1:0] ques_en;
        logic [REG_W-1:0] oper_en;
        logic             cal_bad;
        logic             self_adjust_invalid_bad;
        logic             ready;
        logic             conv_start;
        logic [REG_W-1:0] query_val;
        ser_reply_t       reply;
        logic [2:0]       summary;
        logic             err_led;
    } ser_top_st_t;

endpackage

// ### hw/ser_status_regs.sv
// Status event, condition and enable registers with query answer path
`timescale 1ns/1ps
module ser_status_regs #(
    parameter int BUF_DEPTH = 1024
) (
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  ser_pkg::ser_meas_src_t           meas_src_i,
    input  ser_pkg::ser_ques_src_t           ques_src_i,
    input  ser_pkg::ser_oper_src_t           oper_src_i,
    input  wire logic [ser_pkg::CNT_W-1:0]   buf_count_i,
    input  ser_pkg::ser_query_t              query_i,
    output logic                             query_ready_o,
    input  ser_pkg::ser_enable_wr_t          enable_wr_i,
    input  wire logic                        preset_i,
    output ser_pkg::ser_reply_t              reply_o,
    output logic [2:0]                       summary_o,
    output logic                             err_led_o
);
    import ser_pkg::*;

    ser_top_st_t       st;
    ser_top_st_t       next_st;
    logic [REG_W-1:0]  meas_cond;
    logic [REG_W-1:0]  ques_cond;
    logic [REG_W-1:0]  oper_cond;
    logic              take;
    logic              conv_done;
    logic [BCD_W-1:0]  conv_bcd;

    // ==========================================================
    // Condition registers
    always_comb begin
        meas_cond                = REG_RESET;
        meas_cond[M_OVERRANGE]   = meas_src_i.reading_overrange;
        meas_cond[M_BELOW_ONE]   = meas_src_i.below_lower_bound_one;
        meas_cond[M_ABOVE_ONE]   = meas_src_i.above_upper_bound_one;
        meas_cond[M_BELOW_TWO]   = meas_src_i.below_lower_bound_two;
        meas_cond[M_ABOVE_TWO]   = meas_src_i.above_upper_bound_two;
        meas_cond[M_READY]       = meas_src_i.new_reading_ready;
        meas_cond[M_BUF_TWO]     = buf_count_i >= 16'h0002;
        meas_cond[M_BUF_HALF]    = buf_count_i >= CNT_W'(BUF_DEPTH / 2);
        meas_cond[M_BUF_NOSPACE] = buf_count_i >= CNT_W'(BUF_DEPTH);

        ques_cond                = REG_RESET;
        ques_cond[Q_JUNCTION]    = ques_src_i.junction_invalid;
        ques_cond[Q_CAL_CONST]   = st.cal_bad;
        ques_cond[Q_SELF_ADJUST] = st.self_adjust_invalid_bad;

        oper_cond                = REG_RESET;
        oper_cond[O_CALIBRATING] = oper_src_i.calibrating;
        oper_cond[O_MEASURING]   = oper_src_i.measuring;
        oper_cond[O_TRIG_WAIT]   = oper_src_i.trig_wait;
        oper_cond[O_FILTER_OK]   = oper_src_i.filter_settled;
        oper_cond[O_IDLE]        = oper_src_i.idle;
    end

    assign take = query_i.valid && st.ready;

    // ==========================================================
    // State update
    always_comb begin
        next_st = st;
        next_st.conv_start  = 1'b0;
        next_st.reply.valid = 1'b0;

        // Set wins over clear for both sticky faults
        if (ques_src_i.cal_ok) begin
            next_st.cal_bad = 1'b0;
        end
        if (ques_src_i.cal_const_bad) begin
            next_st.cal_bad = 1'b1;
        end
        if (ques_src_i.self_adjust_ok) begin
            next_st.self_adjust_invalid_bad = 1'b0;
        end
        if (ques_src_i.self_adjust_invalid) begin
            next_st.self_adjust_invalid_bad = 1'b1;
        end

        // Latch until read; a read clears but live sources re-set
        next_st.meas_ev = (st.meas_ev | meas_cond) & MEAS_MASK;
        next_st.ques_ev = (st.ques_ev | ques_cond) & QUES_MASK;
        next_st.oper_ev = (st.oper_ev | oper_cond) & OPER_MASK;

        if (take) begin
            next_st.ready      = 1'b0;
            next_st.conv_start = 1'b1;
            case (query_i.sel)
                QRY_MEAS_EV: begin
                    next_st.query_val = st.meas_ev;
                    next_st.meas_ev   = meas_cond & MEAS_MASK;
                end
                QRY_QUES_EV: begin
                    next_st.query_val = st.ques_ev;
                    next_st.ques_ev   = ques_cond & QUES_MASK;
                end
                QRY_OPER_EV: begin
                    next_st.query_val = st.oper_ev;
                    next_st.oper_ev   = oper_cond & OPER_MASK;
                end
                QRY_MEAS_COND: next_st.query_val = meas_cond;
                QRY_QUES_COND: next_st.query_val = ques_cond;
                QRY_OPER_COND: next_st.query_val = oper_cond;
                default:       next_st.query_val = REG_RESET;
            endcase
        end

        if (conv_done) begin
            next_st.ready        = 1'b1;
            next_st.reply.valid  = 1'b1;
            next_st.reply.digits = conv_bcd;
        end

        if (enable_wr_i.valid) begin
            case (enable_wr_i.sel)
                EN_MEAS: next_st.meas_en = enable_wr_i.data & MEAS_MASK;
                EN_QUES: next_st.ques_en = enable_wr_i.data & QUES_MASK;
                EN_OPER: next_st.oper_en = enable_wr_i.data & OPER_MASK;
                default: next_st.meas_en = st.meas_en;
            endcase
        end
        // Preset wins over a write in the same cycle
        if (preset_i) begin
            next_st.meas_en = REG_RESET;
            next_st.ques_en = REG_RESET;
            next_st.oper_en = REG_RESET;
        end

        next_st.summary[0] = |(st.meas_ev & st.meas_en);
        next_st.summary[1] = |(st.ques_ev & st.ques_en);
        next_st.summary[2] = |(st.oper_ev & st.oper_en);
        next_st.err_led    = |ques_cond;

        if (!nrst_i) begin
            next_st       = '0;
            next_st.ready = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ==========================================================
    // Decimal conversion of the captured value
    ser_dec_conv u_conv (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .start_i (st.conv_start),
        .bin_i   (st.query_val),
        .done_o  (conv_done),
        .bcd_o   (conv_bcd)
    );

    assign query_ready_o = st.ready;
    assign reply_o       = st.reply;
    assign summary_o     = st.summary;
    assign err_led_o     = st.err_led;

    // ==========================================================
    // Checks
    function automatic logic [19:0] from_digits(input logic [BCD_W-1:0] d);
        logic [19:0] acc;
        acc = '0;
        for (int i = DIGITS - 1; i >= 0; i--) begin
            acc = 20'((acc * 20'd10) + 20'(d[4*i +: 4]));
        end
        return acc;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_read_clears;
        take && query_i.sel == QRY_MEAS_EV |=> st.meas_ev == ($past(meas_cond) & MEAS_MASK);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_reply_value;
        take |-> ##19 reply_o.valid
            && from_digits(reply_o.digits) == 20'(st.query_val);
    endproperty
    a_reply_value: assert property (p_reply_value) else $error("bad decimal reply");

    property p_overrange;
        meas_src_i.reading_overrange |=> st.meas_ev[M_OVERRANGE];
    endproperty
    a_overrange: assert property (p_overrange) else $error("overrange not latched");

    property p_buf_two;
        buf_count_i >= 16'h0002 |=> st.meas_ev[M_BUF_TWO];
    endproperty
    a_buf_two: assert property (p_buf_two) else $error("buffer two not latched");

    property p_buf_full;
        buf_count_i == CNT_W'(BUF_DEPTH) |=> st.meas_ev[M_BUF_NOSPACE] && st.meas_ev[M_BUF_HALF];
    endproperty
    a_buf_full: assert property (p_buf_full) else $error("full not latched");

    property p_cal_clear;
        ques_src_i.cal_ok && !ques_src_i.cal_const_bad |=> !st.cal_bad;
    endproperty
    a_cal_clear: assert property (p_cal_clear) else $error("cal fault stuck");

    property p_self_adjust_invalid_set;
        ques_src_i.self_adjust_invalid |=> st.self_adjust_invalid_bad ##1 st.ques_ev[Q_SELF_ADJUST];
    endproperty
    a_self_adjust_invalid_set: assert property (p_self_adjust_invalid_set) else $error("self adjust fault lost");

    property p_err_led;
        ##1 err_led_o == $past(|ques_cond);
    endproperty
    a_err_led: assert property (p_err_led) else $error("indicator mismatch");

    property p_masked;
        !$past(|(st.oper_ev & st.oper_en)) |-> !summary_o[2];
    endproperty
    a_masked: assert property (p_masked) else $error("masked summary raised");

    property p_unused_zero;
        (st.meas_ev & ~MEAS_MASK) == '0 && (st.ques_ev & ~QUES_MASK) == '0
            && (st.oper_ev & ~OPER_MASK) == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_latch;
        st.oper_ev[O_IDLE] && !(take && query_i.sel == QRY_OPER_EV) |=> st.oper_ev[O_IDLE];
    endproperty
    a_latch: assert property (p_latch) else $error("event lost before read");

    property p_low_one;
        meas_src_i.below_lower_bound_one |=> st.meas_ev[M_BELOW_ONE];
    endproperty
    a_low_one: assert property (p_low_one) else $error("low bound one lost");

    property p_high_one;
        meas_src_i.above_upper_bound_one |=> st.meas_ev[M_ABOVE_ONE];
    endproperty
    a_high_one: assert property (p_high_one) else $error("high bound one lost");

    property p_low_two;
        meas_src_i.below_lower_bound_two |=> st.meas_ev[M_BELOW_TWO];
    endproperty
    a_low_two: assert property (p_low_two) else $error("low bound two lost");

    property p_high_two;
        meas_src_i.above_upper_bound_two |=> st.meas_ev[M_ABOVE_TWO];
    endproperty
    a_high_two: assert property (p_high_two) else $error("high bound two lost");

    property p_new_ready;
        meas_src_i.new_reading_ready |=> st.meas_ev[M_READY];
    endproperty
    a_new_ready: assert property (p_new_ready) else $error("reading ready lost");

    property p_buf_half;
        buf_count_i >= CNT_W'(BUF_DEPTH / 2) |=> st.meas_ev[M_BUF_HALF];
    endproperty
    a_buf_half: assert property (p_buf_half) else $error("half full lost");

    property p_junction;
        ques_src_i.junction_invalid |=> st.ques_ev[Q_JUNCTION];
    endproperty
    a_junction: assert property (p_junction) else $error("junction fault lost");

    property p_calibrating;
        oper_src_i.calibrating |=> st.oper_ev[O_CALIBRATING];
    endproperty
    a_calibrating: assert property (p_calibrating) else $error("calibrating lost");

    property p_idle;
        oper_src_i.idle |=> st.oper_ev[O_IDLE];
    endproperty
    a_idle: assert property (p_idle) else $error("idle lost");

    property p_cond_live;
        take && query_i.sel == QRY_OPER_COND |=> st.query_val[O_IDLE] == $past(oper_src_i.idle);
    endproperty
    a_cond_live: assert property (p_cond_live) else $error("condition not live");

    c_reply:   cover property (reply_o.valid && reply_o.digits != '0);
    c_clear:   cover property (take && query_i.sel == QRY_QUES_EV && st.ques_ev != '0);
    c_summary: cover property (summary_o[0]);
    c_err:     cover property (err_led_o ##1 !err_led_o);

endmodule // ser_status_regs

// ### tb/ser_host_model.sv
// Remote computer model: issues status queries and decodes the decimal replies
`timescale 1ns/1ps
module ser_host_model (
    input  wire logic           clk_i,
    input  wire logic           nrst_i,
    input  wire logic           start_i,
    input  wire logic [2:0]     sel_i,
    input  wire logic           ready_i,
    input  ser_pkg::ser_reply_t reply_i,
    output ser_pkg::ser_query_t query_o,
    output logic                done_o,
    output logic [15:0]         value_o
);
    import ser_pkg::*;
    logic pend;

    // ==========================================================
    // Decimal digits back to binary weights
    function automatic logic [15:0] dec2bin(input logic [BCD_W-1:0] d);
        int acc;
        acc = 0;
        for (int i = DIGITS - 1; i >= 0; i--) begin
            acc = acc * 10 + int'(d[4*i +: 4]);
        end
        return acc[15:0];
    endfunction

    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (!nrst_i) begin
            query_o <= '0;
            pend    <= 1'b0;
            value_o <= '0;
        end else begin
            if (query_o.valid && ready_i) begin
                // Released selector is inverted so a stale code never looks held
                query_o <= '{valid: 1'b0, sel: ~query_o.sel};
            end else if (start_i && !pend) begin
                query_o <= '{valid: 1'b1, sel: sel_i};
                pend    <= 1'b1;
            end
            if (reply_i.valid && pend) begin
                value_o <= dec2bin(reply_i.digits);
                done_o  <= 1'b1;
                pend    <= 1'b0;
            end
        end
    end
endmodule // ser_host_model

// ### tb/ser_status_regs_tb.sv
// Self-checking bench for the status event register bank
`timescale 1ns/1ps
module ser_status_regs_tb;
    import ser_pkg::*;
    localparam int BDEP = 8;
    localparam int MPOS [6] = '{M_OVERRANGE, M_BELOW_ONE, M_ABOVE_ONE,
                                M_BELOW_TWO, M_ABOVE_TWO, M_READY};
    localparam int OPOS [5] = '{O_CALIBRATING, O_MEASURING, O_TRIG_WAIT,
                                O_FILTER_OK, O_IDLE};
    logic             clk_i = 1'b0;
    logic             nrst_i = 1'b0;
    ser_meas_src_t    meas_src = '0;
    ser_ques_src_t    ques_src = '0;
    ser_oper_src_t    oper_src = '0;
    logic [CNT_W-1:0] buf_count = '0;
    ser_query_t       query;
    logic             query_ready;
    ser_enable_wr_t   enable_wr = '0;
    logic             preset = 1'b0;
    ser_reply_t       reply;
    logic [2:0]       summary;
    logic             err_led;
    logic             h_start = 1'b0;
    logic [2:0]       h_sel = 3'h0;
    logic             h_done;
    logic [15:0]      h_value;
    int               n_mismatch = 0;
    int               n_compared = 0;

    always #50 clk_i = ~clk_i;

    ser_status_regs #(.BUF_DEPTH(BDEP)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .meas_src_i(meas_src), .ques_src_i(ques_src),
        .oper_src_i(oper_src), .buf_count_i(buf_count), .query_i(query),
        .query_ready_o(query_ready), .enable_wr_i(enable_wr), .preset_i(preset),
        .reply_o(reply), .summary_o(summary), .err_led_o(err_led));

    ser_host_model host (
        .clk_i(clk_i), .nrst_i(nrst_i), .start_i(h_start), .sel_i(h_sel),
        .ready_i(query_ready), .reply_i(reply), .query_o(query), .done_o(h_done),
        .value_o(h_value));

    // ==========================================================
    // Expectations
    function automatic logic [15:0] m_exp(input logic [5:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 6; i++) if (v[5-i]) r[MPOS[i]] = 1'b1;
        return r;
    endfunction

    function automatic logic [15:0] o_exp(input logic [4:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 5; i++) if (v[4-i]) r[OPOS[i]] = 1'b1;
        return r;
    endfunction

    function automatic logic [15:0] b_exp(input int c);
        logic [15:0] r;
        r = '0;
        r[M_BUF_TWO]     = (c >= 2);
        r[M_BUF_HALF]    = (c >= BDEP / 2);
        r[M_BUF_NOSPACE] = (c >= BDEP);
        return r;
    endfunction

    // ==========================================================
    // Helpers
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic cq(input logic [2:0] s, input logic [15:0] e, input string w);
        int k;
        h_start <= 1'b1;
        h_sel   <= s;
        tick(1);
        h_start <= 1'b0;
        // Reply is due about 21 edges out; the bound leaves margin
        for (k = 0; k < 40; k++) begin
            tick(1);
            if (h_done === 1'b1) break;
        end
        if (k == 40) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no reply to query", $time);
            close_out();
        end
        chk(h_value, e, w);
    endtask

    task automatic flt(input ser_ques_src_t s, input ser_ques_src_t c, input logic [15:0] e);
        ques_src <= s;
        tick(1);
        ques_src <= '0;
        tick(3);
        chk(16'(err_led), 16'h0001, "sticky fault lights led");
        cq(QRY_QUES_EV, e, "fault event");
        cq(QRY_QUES_COND, e, "fault stays after read");
        ques_src <= c;
        tick(1);
        ques_src <= '0;
        tick(3);
        cq(QRY_QUES_COND, 16'h0000, "fault cleared");
        chk(16'(err_led), 16'h0000, "led off after clear");
        cq(QRY_QUES_EV, e, "event held until read");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] em;
        logic [15:0] en;
        logic [15:0] eo;
        logic [5:0]  rm;
        logic [4:0]  ro;
        int          cnts [5];
        cnts = '{1, 3, 4, 7, 8};
        void'($urandom(32'h06e0c0fc));
        tick(6);
        chk(16'({query_ready, reply.valid, summary, err_led}), 16'h0020, "reset");
        nrst_i <= 1'b1;
        tick(1);
        for (int i = 0; i < 3; i++) cq(3'(i), 16'h0000, "event after reset");
        cq(3'h6, 16'h0000, "unmapped query");
        for (int i = 0; i < 6; i++) begin
            meas_src <= ser_meas_src_t'(6'h20 >> i);
            tick(1);
            meas_src <= '0;
            tick(2);
            cq(QRY_MEAS_EV, m_exp(6'h20 >> i), "meas bit");
            cq(QRY_MEAS_EV, 16'h0000, "meas cleared");
        end
        foreach (cnts[j]) begin
            buf_count <= 16'(cnts[j]);
            tick(2);
            cq(QRY_MEAS_COND, b_exp(cnts[j]), "buffer cond");
            buf_count <= '0;
            tick(2);
            cq(QRY_MEAS_EV, b_exp(cnts[j]), "buffer event");
        end
        for (int i = 0; i < 5; i++) begin
            oper_src <= ser_oper_src_t'(5'h10 >> i);
            tick(1);
            oper_src <= '0;
            tick(2);
            cq(QRY_OPER_EV, o_exp(5'h10 >> i), "oper bit");
        end
        oper_src <= '{calibrating: 1'b1, default: 1'b0};
        tick(2);
        cq(QRY_OPER_COND, 16'h0001, "oper cond");
        cq(QRY_OPER_COND, 16'h0001, "cond kept");
        oper_src <= '0;
        tick(2);
        cq(QRY_OPER_EV, 16'h0001, "oper latched");
        enable_wr <= '{valid: 1'b1, sel: EN_QUES, data: 16'hFFFF};
        ques_src  <= '{junction_invalid: 1'b1, default: 1'b0};
        tick(1);
        // Selector 3 must leave every mask alone
        enable_wr <= '{valid: 1'b1, sel: 2'h3, data: 16'h0000};
        tick(2);
        chk(16'(err_led), 16'h0001, "junction led");
        chk(16'(summary), 16'h0002, "ques summary");
        enable_wr <= '0;
        ques_src  <= '0;
        tick(3);
        chk(16'(err_led), 16'h0000, "junction led off");
        cq(QRY_QUES_EV, 16'h0010, "junction event");
        flt('{cal_const_bad: 1'b1, default: 1'b0}, '{cal_ok: 1'b1, default: 1'b0},
            16'h0100);
        flt('{self_adjust_invalid: 1'b1, default: 1'b0},
            '{self_adjust_ok: 1'b1, default: 1'b0}, 16'h0200);
        // Masked event must not reach the summary
        enable_wr <= '{valid: 1'b1, sel: EN_MEAS, data: 16'h0220};
        meas_src  <= '{reading_overrange: 1'b1, default: 1'b0};
        tick(1);
        enable_wr <= '0;
        meas_src  <= '{new_reading_ready: 1'b0, default: 1'b0};
        tick(3);
        chk(16'(summary), 16'h0000, "masked bit");
        meas_src <= '{new_reading_ready: 1'b1, default: 1'b0};
        tick(1);
        meas_src <= '0;
        tick(3);
        chk(16'(summary), 16'h0001, "unmasked bit");
        cq(QRY_MEAS_EV, 16'h0021, "both latched");
        tick(2);
        chk(16'(summary), 16'h0000, "summary after read");
        // Preset wins over a write at the same edge
        enable_wr <= '{valid: 1'b1, sel: EN_MEAS, data: 16'hFFFF};
        preset    <= 1'b1;
        meas_src  <= '{reading_overrange: 1'b1, default: 1'b0};
        tick(1);
        enable_wr <= '0;
        preset    <= 1'b0;
        meas_src  <= '0;
        tick(3);
        chk(16'(summary), 16'h0000, "preset masks");
        cq(QRY_MEAS_EV, 16'h0001, "preset keeps events");
        for (int r = 0; r < 16; r++) begin
            rm = 6'($urandom);
            ro = 5'($urandom);
            en = 16'($urandom);
            eo = 16'($urandom);
            enable_wr <= '{valid: 1'b1, sel: EN_MEAS, data: en};
            meas_src  <= ser_meas_src_t'(rm);
            oper_src  <= ser_oper_src_t'(ro);
            tick(1);
            enable_wr <= '{valid: 1'b1, sel: EN_OPER, data: eo};
            meas_src  <= '0;
            oper_src  <= '0;
            tick(1);
            enable_wr <= '0;
            tick(2);
            em = m_exp(rm);
            chk(16'(summary[0]), 16'(|(em & en)), "random summary");
            chk(16'(summary[2]), 16'(|(o_exp(ro) & eo)), "random oper summary");
            cq(QRY_MEAS_EV, em, "random meas");
            cq(QRY_OPER_EV, o_exp(ro), "random oper");
        end
        // Preset must drop the operation mask as well
        enable_wr <= '{valid: 1'b1, sel: EN_OPER, data: 16'hFFFF};
        oper_src  <= '{idle: 1'b1, default: 1'b0};
        tick(1);
        enable_wr <= '0;
        oper_src  <= '0;
        preset    <= 1'b1;
        tick(1);
        preset    <= 1'b0;
        tick(2);
        chk(16'(summary), 16'h0000, "preset clears oper mask");
        close_out();
    end
endmodule // ser_status_regs_tb
